/* File: src/rfs_pkg.sv */
package rfs_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_FREQ_HZ      = 25_000_000;
  localparam int GATE_TIME_MS     = 1000;
  localparam int MS_PER_S         = 1000;
  localparam int GATE_CYCLES_DFLT = (CLK_FREQ_HZ / MS_PER_S) * GATE_TIME_MS;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_SELECT   = 8'h00;
  localparam logic [7:0] OFS_SOURCES  = 8'h04;
  localparam logic [7:0] OFS_MODE     = 8'h08;
  localparam logic [7:0] OFS_MIN_F    = 8'h0c;
  localparam logic [7:0] OFS_MAX_F    = 8'h10;
  localparam logic [7:0] OFS_MAX_PCT  = 8'h14;
  localparam logic [7:0] OFS_BLK1     = 8'h18;
  localparam logic [7:0] OFS_BLK2     = 8'h1c;
  localparam logic [7:0] OFS_HYST     = 8'h20;
  localparam logic [7:0] OFS_DIVIDER  = 8'h24;
  localparam logic [7:0] OFS_SCALE_A  = 8'h28;
  localparam logic [7:0] OFS_SCALE_B  = 8'h2c;
  localparam logic [7:0] OFS_PULSE_SC = 8'h30;
  localparam logic [2:0] OFS_FIX_PAGE = 3'h2;
  localparam logic [7:0] OFS_REF_OUT  = 8'h60;
  localparam logic [7:0] OFS_PCT_REF  = 8'h64;
  localparam logic [7:0] OFS_EDGES    = 8'h68;
  localparam logic [7:0] OFS_DUTY     = 8'h6c;
  localparam logic [7:0] OFS_INPUTS   = 8'h70;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SEL_A_LSB = 0;
  localparam int SEL_B_LSB = 8;
  localparam int SEL_C_LSB = 16;
  localparam int SRC_F1_LSB = 0;
  localparam int SRC_F2_LSB = 8;
  localparam int SRC_P1_LSB = 16;
  localparam int SRC_P2_LSB = 24;
  localparam int INP_CODE_LSB = 8;

  // ****************************************************************
  // Codes
  // ****************************************************************
  localparam logic [6:0] SEL_OFF      = 7'h07;
  localparam logic [6:0] SEL_IN_FIRST = 7'h47;
  localparam logic [6:0] SEL_IN_LAST  = 7'h4d;
  localparam logic [7:0] SRC_FIXED    = 8'h03;
  localparam logic [7:0] SRC_FREQ_IN  = 8'h0a;
  localparam logic [7:0] MODE_PWM     = 8'h0a;
  localparam logic [7:0] MODE_PWM_SGN = 8'h0b;
  localparam logic [7:0] MODE_RF_ONE  = 8'h14;
  localparam logic [7:0] MODE_RF_TWO  = 8'h15;
  localparam logic [7:0] MODE_PULSE   = 8'h1e;

  // Setpoint index chosen by select code {s1,s2,s3}
  localparam logic [7:0][2:0] FIXED_MAP = {3'h5, 3'h2, 3'h6, 3'h1, 3'h4, 3'h3, 3'h7, 3'h0};

  // ****************************************************************
  // Reset values (0.01 Hz, 0.01 %)
  // ****************************************************************
  localparam logic [7:0][15:0] FIXED_RST = {16'h1388, 16'h09c4, 16'h03e8, 16'h01f4,
                                            16'h1388, 16'h09c4, 16'h03e8, 16'h0000};
  localparam logic [15:0] MIN_F_RST    = 16'h0000;
  localparam logic [15:0] MAX_F_RST    = 16'h1388;
  localparam logic [15:0] MAX_PCT_RST  = 16'h2710;
  localparam logic [15:0] BLK_RST      = 16'h0000;
  localparam logic [15:0] HYST_RST     = 16'h0000;
  localparam logic [15:0] DIVIDER_RST  = 16'h0001;
  localparam logic [15:0] SCALE_RST    = 16'h0064;
  localparam logic [31:0] PULSE_SC_RST = 32'h000061a8;
  localparam logic [15:0] PCT_FULL     = 16'h2710;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [6:0]       sel_a;
    logic [6:0]       sel_b;
    logic [6:0]       sel_c;
    logic [7:0]       fsrc1;
    logic [7:0]       fsrc2;
    logic [7:0]       psrc1;
    logic [7:0]       psrc2;
    logic [7:0]       mode;
    logic [15:0]      min_f;
    logic [15:0]      max_f;
    logic [15:0]      max_pct;
    logic [15:0]      blk1;
    logic [15:0]      blk2;
    logic [15:0]      hyst;
    logic [15:0]      divider;
    logic [15:0]      scale_a;
    logic [15:0]      scale_b;
    logic [31:0]      pulse_sc;
    logic [7:0][15:0] fixed;
  } rfs_cfg_s;

  typedef struct packed {
    rfs_cfg_s           cfg;
    logic [6:0]         in_meta;
    logic [6:0]         in_sync;
    logic               in2_prev;
    logic [31:0]        gate_cnt;
    logic [31:0]        edge_cnt;
    logic [31:0]        high_cnt;
    logic [31:0]        meas_edges;
    logic [15:0]        meas_duty;
    logic [1:0]         blk_side;
    logic signed [31:0] ref_int;
    logic signed [31:0] ref_out;
    logic signed [31:0] pct_ref;
    logic               waitreq;
    logic [31:0]        rdata;
  } rfs_state_s;

endpackage : rfs_pkg

/* File: src/rfs_reference_select.sv */
`timescale 1ns/1ps
// Summary of operation
// - Select code {s1,s2,s3} picks one of eight setpoints by the fixed table.
// - Eight setpoints reset to 0,10,25,50,5,10,25,50 Hz; each writable.
// - Select source code 7 gives zero; 71..77 route an input.
// - Fixed setpoint feeds the reference when a frequency source selector is 3.
// - Output reference magnitude is clamped between minimum and maximum frequency; the sign is kept.
// - Two blocking frequencies, reset 0 Hz, are kept out of the output.
// - Band of plus/minus hysteresis around each blocking frequency is forbidden.
// - Mode 10 maps input-two duty 0..100 % onto zero to maximum.
// - Mode 11 maps duty onto -100..+100 % of maximum.
// - PWM reference scaled by two factors; percent output when selector is 10.
// - Mode 20 counts one edge polarity, mode 21 counts both.
// - Repetition frequency is divided by a configurable divider.
// - Frequency input feeds the reference when a frequency source selector is 10.
// - Mode 30: scaling frequency (25000 Hz) corresponds to maximum frequency.
module rfs_reference_select
  import rfs_pkg::*;
#(
  parameter int GATE_CYCLES = GATE_CYCLES_DFLT
)(
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  // Avalon-MM slave
  input  wire logic [7:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // Plant digital inputs
  input  wire logic               digital_input_one,
  input  wire logic               digital_input_two,
  input  wire logic               digital_input_three,
  input  wire logic               digital_input_four,
  input  wire logic               digital_input_five,
  input  wire logic               multifunction_input_one,
  input  wire logic               multifunction_input_two,
  // References
  output logic signed [31:0]      freq_reference,
  output logic signed [31:0]      percent_reference
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (GATE_CYCLES < 16)
  begin : g_gate_check
    $error("GATE_CYCLES too small");
  end

  // ****************************************************************
  // State
  // ****************************************************************
  rfs_state_s         q;
  rfs_state_s         n;
  logic [6:0]         din_raw;
  logic [31:0]        rdv;
  logic [31:0]        wv;
  logic [31:0]        bmask;
  logic               req;
  logic               wr_go;
  logic               rise;
  logic               fall;
  logic               edge_hit;
  logic               gate_end;
  logic [2:0]         sel_code;
  logic [15:0]        fixed_val;
  logic signed [63:0] f_hz;
  logic signed [63:0] span;
  logic signed [63:0] scale_b_nz;
  logic signed [63:0] div_nz;
  logic signed [63:0] psc_nz;
  logic signed [63:0] fin_val;
  logic signed [63:0] pin_val;
  logic signed [63:0] sgn_max_f;
  logic signed [63:0] sgn_max_pct;
  logic signed [63:0] sgn_pct_full;
  logic signed [63:0] sgn_scale_a;
  logic signed [31:0] x;
  logic signed [31:0] lo;
  logic signed [31:0] hi;
  logic signed [31:0] mag;

  // ****************************************************************
  // Pin gathering
  // ****************************************************************
  assign din_raw = {multifunction_input_two, multifunction_input_one, digital_input_five,
                    digital_input_four, digital_input_three, digital_input_two, digital_input_one};

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic sel_bit(input logic [6:0] code, input logic [6:0] s);
    logic [6:0] idx;
    idx = code - SEL_IN_FIRST;
    if (code >= SEL_IN_FIRST && code <= SEL_IN_LAST)
      return s[idx[2:0]];
    return 1'b0;
  endfunction : sel_bit

  function automatic logic signed [63:0] pick(input logic [7:0] sel, input logic signed [63:0] fixv,
                                              input logic signed [63:0] finv);
    if (sel == SRC_FIXED)
      return fixv;
    if (sel == SRC_FREQ_IN)
      return finv;
    return 64'sh0;
  endfunction : pick

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  always_comb
  begin
    rdv = 32'h0;
    if (avs_address[7:5] == OFS_FIX_PAGE && avs_address[1:0] == 2'h0)
      rdv = {16'h0, q.cfg.fixed[avs_address[4:2]]};
    else
    begin
      unique case (avs_address)
        OFS_SELECT:   rdv = {9'h0, q.cfg.sel_c, 1'b0, q.cfg.sel_b, 1'b0, q.cfg.sel_a};
        OFS_SOURCES:  rdv = {q.cfg.psrc2, q.cfg.psrc1, q.cfg.fsrc2, q.cfg.fsrc1};
        OFS_MODE:     rdv = {24'h0, q.cfg.mode};
        OFS_MIN_F:    rdv = {16'h0, q.cfg.min_f};
        OFS_MAX_F:    rdv = {16'h0, q.cfg.max_f};
        OFS_MAX_PCT:  rdv = {16'h0, q.cfg.max_pct};
        OFS_BLK1:     rdv = {16'h0, q.cfg.blk1};
        OFS_BLK2:     rdv = {16'h0, q.cfg.blk2};
        OFS_HYST:     rdv = {16'h0, q.cfg.hyst};
        OFS_DIVIDER:  rdv = {16'h0, q.cfg.divider};
        OFS_SCALE_A:  rdv = {16'h0, q.cfg.scale_a};
        OFS_SCALE_B:  rdv = {16'h0, q.cfg.scale_b};
        OFS_PULSE_SC: rdv = q.cfg.pulse_sc;
        OFS_REF_OUT:  rdv = q.ref_out;
        OFS_PCT_REF:  rdv = q.pct_ref;
        OFS_EDGES:    rdv = q.meas_edges;
        OFS_DUTY:     rdv = {16'h0, q.meas_duty};
        OFS_INPUTS:   rdv = {21'h0, sel_code, 1'b0, q.in_sync};
        default:      rdv = 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    n = q;
    // ********************
    // Avalon handshake: one wait cycle, then one ready cycle
    // ********************
    req   = avs_read | avs_write;
    wr_go = avs_write & ~q.waitreq;
    n.waitreq = ~(req & q.waitreq);
    if (req && q.waitreq)
      n.rdata = rdv;
    bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    wv    = (rdv & ~bmask) | (avs_writedata & bmask);
    if (wr_go)
    begin
      if (avs_address[7:5] == OFS_FIX_PAGE && avs_address[1:0] == 2'h0)
        n.cfg.fixed[avs_address[4:2]] = wv[15:0];
      else
      begin
        unique case (avs_address)
          OFS_SELECT:
          begin
            n.cfg.sel_a = wv[SEL_A_LSB +: 7];
            n.cfg.sel_b = wv[SEL_B_LSB +: 7];
            n.cfg.sel_c = wv[SEL_C_LSB +: 7];
          end
          OFS_SOURCES:
          begin
            n.cfg.fsrc1 = wv[SRC_F1_LSB +: 8];
            n.cfg.fsrc2 = wv[SRC_F2_LSB +: 8];
            n.cfg.psrc1 = wv[SRC_P1_LSB +: 8];
            n.cfg.psrc2 = wv[SRC_P2_LSB +: 8];
          end
          OFS_MODE:     n.cfg.mode     = wv[7:0];
          OFS_MIN_F:    n.cfg.min_f    = wv[15:0];
          OFS_MAX_F:    n.cfg.max_f    = wv[15:0];
          OFS_MAX_PCT:  n.cfg.max_pct  = wv[15:0];
          OFS_BLK1:     n.cfg.blk1     = wv[15:0];
          OFS_BLK2:     n.cfg.blk2     = wv[15:0];
          OFS_HYST:     n.cfg.hyst     = wv[15:0];
          OFS_DIVIDER:  n.cfg.divider  = wv[15:0];
          OFS_SCALE_A:  n.cfg.scale_a  = wv[15:0];
          OFS_SCALE_B:  n.cfg.scale_b  = wv[15:0];
          OFS_PULSE_SC: n.cfg.pulse_sc = wv;
          default:      n.cfg.mode     = q.cfg.mode;
        endcase
      end
    end

    // ********************
    // Input synchroniser and edge detection on input two
    // ********************
    n.in_meta  = din_raw;
    n.in_sync  = q.in_meta;
    n.in2_prev = q.in_sync[1];
    rise     = q.in_sync[1] & ~q.in2_prev;
    fall     = ~q.in_sync[1] & q.in2_prev;
    edge_hit = rise | (fall & (q.cfg.mode == MODE_RF_TWO));

    // ********************
    // Gate measurement: edges and high time over a fixed window
    // ********************
    gate_end = (q.gate_cnt == 32'(GATE_CYCLES - 1));
    if (gate_end)
    begin
      n.gate_cnt   = 32'h0;
      n.edge_cnt   = 32'h0;
      n.high_cnt   = 32'h0;
      n.meas_edges = q.edge_cnt + {31'h0, edge_hit};
      n.meas_duty  = 16'((64'(q.high_cnt + {31'h0, q.in_sync[1]}) * 64'(PCT_FULL)) / 64'(GATE_CYCLES));
    end
    else
    begin
      n.gate_cnt = q.gate_cnt + 32'h1;
      n.edge_cnt = q.edge_cnt + {31'h0, edge_hit};
      n.high_cnt = q.high_cnt + {31'h0, q.in_sync[1]};
    end

    // ********************
    // Fixed frequency selection
    // ********************
    sel_code  = {sel_bit(q.cfg.sel_a, q.in_sync), sel_bit(q.cfg.sel_b, q.in_sync),
                 sel_bit(q.cfg.sel_c, q.in_sync)};
    fixed_val = q.cfg.fixed[FIXED_MAP[sel_code]];

    // ********************
    // Frequency input evaluation
    // ********************
    f_hz       = 64'(q.meas_edges) * 64'(MS_PER_S) / 64'(GATE_TIME_MS);
    scale_b_nz = (q.cfg.scale_b == 16'h0) ? 64'sh1 : 64'(q.cfg.scale_b);
    div_nz     = (q.cfg.divider == 16'h0) ? 64'sh1 : 64'(q.cfg.divider);
    psc_nz     = (q.cfg.pulse_sc == 32'h0) ? 64'sh1 : 64'(q.cfg.pulse_sc);
    sgn_max_f    = $signed(64'(q.cfg.max_f));
    sgn_max_pct  = $signed(64'(q.cfg.max_pct));
    sgn_pct_full = $signed(64'(PCT_FULL));
    sgn_scale_a  = $signed(64'(q.cfg.scale_a));
    span       = 64'(q.meas_duty);
    if (q.cfg.mode == MODE_PWM_SGN)
      span = 64'(q.meas_duty) * 64'sh2 - 64'(PCT_FULL);
    fin_val = 64'sh0;
    pin_val = 64'sh0;
    unique case (q.cfg.mode)
      MODE_PWM, MODE_PWM_SGN:
      begin
        fin_val = span * sgn_max_f / sgn_pct_full * sgn_scale_a / scale_b_nz;
        pin_val = span * sgn_max_pct / sgn_pct_full * sgn_scale_a / scale_b_nz;
      end
      MODE_RF_ONE, MODE_RF_TWO:
        fin_val = f_hz * 64'sh64 / div_nz;
      MODE_PULSE:
      begin
        fin_val = f_hz * 64'(q.cfg.max_f) / psc_nz;
        pin_val = f_hz * 64'(q.cfg.max_pct) / psc_nz;
      end
      default:
      begin
        fin_val = 64'sh0;
        pin_val = 64'sh0;
      end
    endcase

    // ********************
    // Reference source selection, both selectors summed
    // ********************
    n.ref_int = 32'(pick(q.cfg.fsrc1, 64'(fixed_val), fin_val)
                  + pick(q.cfg.fsrc2, 64'(fixed_val), fin_val));
    n.pct_ref = 32'(((q.cfg.psrc1 == SRC_FREQ_IN) ? pin_val : 64'sh0)
                  + ((q.cfg.psrc2 == SRC_FREQ_IN) ? pin_val : 64'sh0));

    // ********************
    // Blocking bands with edge hold
    // ********************
    x = q.ref_int;
    for (int i = 0; i < 2; i++)
    begin
      lo = 32'((i == 0) ? q.cfg.blk1 : q.cfg.blk2) - 32'(q.cfg.hyst);
      hi = 32'((i == 0) ? q.cfg.blk1 : q.cfg.blk2) + 32'(q.cfg.hyst);
      if (x <= lo)
        n.blk_side[i] = 1'b0;
      else if (x >= hi)
        n.blk_side[i] = 1'b1;
      else
        x = q.blk_side[i] ? hi : lo;
    end

    // ********************
    // Magnitude clamp between minimum and maximum frequency
    // ********************
    mag = (x < 0) ? -x : x;
    if (mag < 32'(q.cfg.min_f))
      mag = 32'(q.cfg.min_f);
    if (mag > 32'(q.cfg.max_f))
      mag = 32'(q.cfg.max_f);
    n.ref_out = (x < 0) ? -mag : mag;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q              <= '0;
      q.cfg.sel_a    <= SEL_OFF;
      q.cfg.sel_b    <= SEL_OFF;
      q.cfg.sel_c    <= SEL_OFF;
      q.cfg.min_f    <= MIN_F_RST;
      q.cfg.max_f    <= MAX_F_RST;
      q.cfg.max_pct  <= MAX_PCT_RST;
      q.cfg.blk1     <= BLK_RST;
      q.cfg.blk2     <= BLK_RST;
      q.cfg.hyst     <= HYST_RST;
      q.cfg.divider  <= DIVIDER_RST;
      q.cfg.scale_a  <= SCALE_RST;
      q.cfg.scale_b  <= SCALE_RST;
      q.cfg.pulse_sc <= PULSE_SC_RST;
      q.cfg.fixed    <= FIXED_RST;
      q.waitreq      <= 1'b1;
    end
    else
      q <= n;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign avs_readdata      = q.rdata;
  assign avs_waitrequest   = q.waitreq;
  assign freq_reference    = q.ref_out;
  assign percent_reference = q.pct_ref;

endmodule : rfs_reference_select

/* File: tb/rfs_checker_sva.sv */
`timescale 1ns/1ps
module rfs_checker
  import rfs_pkg::*;
#(parameter int GATE_CYCLES = GATE_CYCLES_DFLT)
(
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               resetn,
  // Register bus
  input wire logic [7:0]         avs_address,
  input wire logic               avs_read,
  input wire logic               avs_write,
  input wire logic [31:0]        avs_writedata,
  input wire logic [3:0]         avs_byteenable,
  input wire logic               avs_waitrequest,
  // References
  input wire logic signed [31:0] freq_reference,
  input wire logic signed [31:0] percent_reference
);
  // ********************
  // Shadow settings and checks
  // ********************
  logic [15:0][31:0] sh_q;
  logic [2:0]        settle_q;
  logic              ok;
  int                fr, mag, b1, b2, hy;

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      sh_q     <= '0;
      sh_q[4]  <= {16'h0, MAX_F_RST};
      settle_q <= 3'h0;
    end
    else if (avs_write && !avs_waitrequest)
    begin
      settle_q <= 3'h0;
      for (int b = 0; b < 4; b++)
        if (avs_byteenable[b] && avs_address < 8'h40)
          sh_q[avs_address[5:2]][8*b +: 8] <= avs_writedata[8*b +: 8];
    end
    else if (settle_q != 3'h7)
      settle_q <= settle_q + 3'h1;

  always_comb
  begin
    fr  = int'(freq_reference);
    mag = (fr < 0) ? -fr : fr;
    hy  = int'(sh_q[8][15:0]);
    b1  = int'(sh_q[6][15:0]);
    b2  = int'(sh_q[7][15:0]);
    ok  = settle_q > 3'h2;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  property p_reset_zero;
    $rose(resetn) |-> (freq_reference == 32'sh0 && percent_reference == 32'sh0) [*3];
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reference not zero after reset");
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus request not answered next cycle");
  property p_answer_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_answer_one: assert property (p_answer_one) else $error("waitrequest low too long");
  property p_clamp;
    ok |-> mag >= int'(sh_q[3][15:0]) && mag <= int'(sh_q[4][15:0]);
  endproperty
  a_clamp: assert property (p_clamp) else $error("reference outside min and max");
  property p_band1;
    ok |-> !(fr > b1 - hy && fr < b1 + hy);
  endproperty
  a_band1: assert property (p_band1) else $error("reference inside first band");
  property p_band2;
    ok |-> !(fr > b2 - hy && fr < b2 + hy);
  endproperty
  a_band2: assert property (p_band2) else $error("reference inside second band");
  property p_no_freq;
    ok && !(sh_q[1][7:0] inside {8'h03, 8'h0a}) && !(sh_q[1][15:8] inside {8'h03, 8'h0a})
      |-> fr == int'(sh_q[3][15:0]);
  endproperty
  a_no_freq: assert property (p_no_freq) else $error("reference without source");
  property p_no_pct;
    ok && sh_q[1][23:16] != 8'h0a && sh_q[1][31:24] != 8'h0a |-> percent_reference == 32'sh0;
  endproperty
  a_no_pct: assert property (p_no_pct) else $error("percent without source");
endmodule : rfs_checker

bind rfs_reference_select rfs_checker #(.GATE_CYCLES(GATE_CYCLES)) u_chk (.*);

/* File: tb/rfs_pin_model.sv */
`timescale 1ns/1ps
module rfs_pin_model
(
  // Clock
  input wire logic        sys_clk,
  // Switch levels and pulse shape
  input wire logic [6:0]  lvl,
  input wire logic        pulse_on,
  input wire logic [15:0] period,
  input wire logic [15:0] high_len,
  // Pins towards the block
  output logic [6:0]      pins = 7'h0
);
  // ********************
  // Switches and pulse source
  // ********************
  logic [15:0] cnt_q = 16'h0;

  always_ff @(posedge sys_clk)
  begin
    cnt_q <= (cnt_q + 16'h1 >= period) ? 16'h0 : cnt_q + 16'h1;
    pins  <= pulse_on ? {lvl[6:2], cnt_q < high_len, lvl[0]} : lvl;
  end
endmodule : rfs_pin_model

/* File: tb/rfs_reference_select_tb_top.sv */
`timescale 1ns/1ps
module rfs_reference_select_tb_top;
  import rfs_pkg::*;
  localparam int GATE = 1000;
  logic               sys_clk = 1'b0;
  logic               resetn = 1'b0;
  logic [7:0]         avs_address = 8'h0;
  logic               avs_read = 1'b0;
  logic               avs_write = 1'b0;
  logic [31:0]        avs_writedata = 32'h0;
  logic [3:0]         avs_byteenable = 4'hf;
  logic [31:0]        avs_readdata;
  logic               avs_waitrequest;
  logic [6:0]         lvl = 7'h0;
  logic               pulse_on = 1'b0;
  logic [6:0]         pins;
  logic signed [31:0] freq_reference, percent_reference;
  logic               digital_input_one, digital_input_two, digital_input_three, digital_input_four;
  logic               digital_input_five, multifunction_input_one, multifunction_input_two;
  int                 failures = 0;
  int                 tests_run = 0;
  int                 fix[8] = '{0, 1000, 2500, 5000, 500, 1000, 2500, 5000};
  int                 pick[8] = '{0, 7, 3, 4, 1, 6, 2, 5};
  int                 sv[7] = '{1000, 1800, 2600, 2200, 1600, 1200, 4200};
  int                 se[7] = '{1000, 1500, 2600, 2500, 2500, 1200, 3500};
  int                 md[7] = '{10, 11, 10, 20, 21, 21, 30};
  int                 sa[7] = '{100, 100, 200, 100, 100, 100, 100};
  int                 dv[7] = '{1, 1, 1, 1, 1, 2, 1};
  int                 ps[7] = '{25000, 25000, 25000, 25000, 25000, 25000, 20};
  int                 ef[7] = '{1250, -2500, 2500, 1000, 2000, 1000, 2500};
  int                 ep[7] = '{2500, -5000, 5000, 0, 0, 0, 5000};

  // ********************
  // Harness, bus tasks and scenarios
  // ********************
  always #20 sys_clk = ~sys_clk;
  assign {multifunction_input_two, multifunction_input_one, digital_input_five, digital_input_four,
          digital_input_three, digital_input_two, digital_input_one} = pins;
  rfs_reference_select #(.GATE_CYCLES(GATE)) uut (.*);
  rfs_pin_model u_pins (.sys_clk(sys_clk), .lvl(lvl), .pulse_on(pulse_on), .period(16'h0064),
                        .high_len(16'h0019), .pins(pins));

  task automatic tally_and_finish;
    $display("Checks run %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %0d seen %0d", what, $signed(exp), $signed(got));
      failures++;
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      $display("ERROR avs_waitrequest expected 0 seen 1");
      failures++;
      tally_and_finish();
    end
    else
      @(posedge sys_clk);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic ref_chk(input int f, input int p, input bit with_pct);
    repeat (8) @(posedge sys_clk);
    check("freq_reference", f, freq_reference);
    if (with_pct)
      check("percent_reference", p, percent_reference);
  endtask : ref_chk

  task automatic t_reset;
    logic [31:0] q;
    check("freq_reference", 32'h0, freq_reference);
    for (int k = 0; k < 8; k++)
    begin
      bus(1'b0, 8'(8'h40 + 4 * k), 32'h0, q);
      check("fixed_setpoint", fix[k], q);
    end
    bus(1'b0, OFS_BLK1, 32'h0, q);
    check("blocking_freq_one", 32'h0, q);
    bus(1'b0, OFS_HYST, 32'h0, q);
    check("blocking_hysteresis", 32'h0, q);
    bus(1'b0, OFS_PULSE_SC, 32'h0, q);
    check("pulse_scaling_freq", 32'h000061a8, q);
  endtask : t_reset

  task automatic t_fixed;
    logic [31:0] q;
    wr(OFS_SOURCES, 32'h00000003);
    wr(OFS_SELECT, 32'h00494847);
    for (int c = 0; c < 8; c++)
    begin
      lvl <= {4'h0, c[0], c[1], c[2]};
      ref_chk(fix[pick[c]], 0, 1'b0);
      bus(1'b0, OFS_INPUTS, 32'h0, q);
      check("select code", 32'(c), {29'h0, q[10:8]});
    end
  endtask : t_fixed

  task automatic t_route;
    logic [31:0] q;
    for (int k = 0; k < 8; k++)
    begin
      wr(OFS_SELECT, (k < 7) ? 32'h00070747 + k : 32'h00070707);
      lvl <= (k < 7) ? 7'(1 << k) : 7'h7f;
      repeat (6) @(posedge sys_clk);
      bus(1'b0, OFS_INPUTS, 32'h0, q);
      check("select code", (k < 7) ? 32'h4 : 32'h0, {29'h0, q[10:8]});
    end
  endtask : t_route

  task automatic t_clamp;
    wr(OFS_SELECT, 32'h00070707);
    wr(OFS_SOURCES, 32'h00000300);
    wr(OFS_MIN_F, 32'h000005dc);
    ref_chk(1500, 0, 1'b0);
    wr(OFS_MIN_F, 32'h0);
    wr(OFS_MAX_F, 32'h00000bb8);
    wr(8'h40, 32'h00001388);
    ref_chk(3000, 0, 1'b0);
    wr(OFS_MAX_F, 32'h00001388);
  endtask : t_clamp

  task automatic t_block;
    wr(OFS_BLK1, 32'h000007d0);
    wr(OFS_BLK2, 32'h00000fa0);
    wr(OFS_HYST, 32'h000001f4);
    for (int k = 0; k < 7; k++)
    begin
      wr(8'h40, sv[k]);
      ref_chk(se[k], 0, 1'b0);
    end
    wr(OFS_HYST, 32'h0);
  endtask : t_block

  task automatic t_input;
    pulse_on <= 1'b1;
    for (int r = 0; r < 7; r++)
    begin
      wr(OFS_SOURCES, (r < 4) ? 32'h000a000a : 32'h0a000a00);
      wr(OFS_MODE, md[r]);
      wr(OFS_SCALE_A, sa[r]);
      wr(OFS_DIVIDER, dv[r]);
      wr(OFS_PULSE_SC, ps[r]);
      repeat (2 * GATE) @(posedge sys_clk);
      ref_chk(ef[r], ep[r], md[r] < 20 || md[r] == 30);
    end
  endtask : t_input

  initial
  begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_fixed();
    t_route();
    t_clamp();
    t_block();
    t_input();
    tally_and_finish();
  end
endmodule : rfs_reference_select_tb_top
